// [rtl/sss_pkg.sv]
// Shared types and constants for the system sleep state sequencer.
`default_nettype none
package sss_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int SSS_AW = 8;
	localparam int SSS_NWAKE = 8;
	localparam logic [7:0] SSS_CTRL_OFF = 8'h00;
	localparam logic [7:0] SSS_WEN_OFF = 8'h04;
	localparam logic [7:0] SSS_STAT_OFF = 8'h08;
	localparam logic [7:0] SSS_WSTS_OFF = 8'h0c;
	localparam logic [1:0] SSS_RESP_OK = 2'h0;
	localparam logic [1:0] SSS_RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_FULL_ON,
		ST_CPU_IDLE,
		ST_SUSP_DISK,
		ST_SOFT_OFF,
		ST_DEEP_SLEEP,
		ST_MECH_OFF
	} sss_state_e;

	typedef enum logic [1:0] {
		MGMT_ON,
		MGMT_OFF,
		MGMT_POWERGATED_STATE
	} sss_mgmt_e;

	// Control register, bit 0 upward: sleep request, stay off after
	// power return, override to disk, deep S4 enable, deep S5 enable,
	// host wake-on-LAN, management wake-on-LAN.
	typedef struct packed {
		logic mgmt_wol;
		logic host_wol;
		logic deep_s5_en;
		logic deep_s4_en;
		logic ovr_to_disk;
		logic stay_off;
		logic sleep_request_bit;
	} sss_ctrl_s;

	typedef struct packed {
		logic core_deep_idle_gate_n;
		logic primary_rail_off_n;
		logic lan_rail_off_n;
		logic mgmt_rail_off_n;
		logic soft_off_rail_off_n;
		logic disk_suspend_rail_off_n;
		logic cpu_rail_off_n;
	} sss_rails_s;

	typedef struct packed {
		sss_state_e st;
		logic from_s4;
		logic was_s4;
		sss_rails_s rails;
	} sss_seq_s;

	typedef struct packed {
		logic aw_held;
		logic [7:0] waddr;
		logic w_held;
		logic [7:0] wdata;
		logic wbe;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		sss_ctrl_s ctrl;
		logic [7:0] wen;
		logic [7:0] wsts;
	} sss_reg_s;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam sss_rails_s SSS_RAILS_ON = 7'h7f;
	localparam sss_seq_s SSS_SEQ_RST = '{
		st: ST_FULL_ON, from_s4: 1'b0, was_s4: 1'b0,
		rails: SSS_RAILS_ON};
	localparam sss_reg_s SSS_REG_RST = '0;

	function automatic logic sss_sleeping(input sss_state_e s);
		return s inside {ST_SUSP_DISK, ST_SOFT_OFF, ST_DEEP_SLEEP,
			ST_MECH_OFF};
	endfunction

endpackage
`default_nettype wire

// [rtl/sss_regs.sv]
// AXI4-Lite register slave of the system sleep state sequencer.
`default_nettype none
module sss_regs
	import sss_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic [7:0] wake_evt,
	input wire logic wake_clr,
	input wire logic slp_clr,
	input wire logic [15:0] status,
	output sss_ctrl_s ctrl,
	output logic [7:0] wake_en,
	output logic [7:0] wake_sts
);

	sss_reg_s r;
	sss_reg_s n;
	logic [7:0] sw_clr;

	// ------------------------------------------------------------
	// Bus and register logic
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		sw_clr = 8'h00;
		if (awvalid && r.awready) begin
			n.aw_held = 1'b1;
			n.waddr = awaddr;
		end
		if (wvalid && r.wready) begin
			n.w_held = 1'b1;
			n.wdata = wdata[7:0];
			n.wbe = wstrb[0];
		end
		if (r.bvalid && bready)
			n.bvalid = 1'b0;
		// The hardware clear comes first so a software set still lands.
		if (slp_clr)
			n.ctrl.sleep_request_bit = 1'b0;
		if (r.aw_held && r.w_held) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = SSS_RESP_OK;
			if (r.waddr == SSS_CTRL_OFF) begin
				if (r.wbe)
					n.ctrl = r.wdata[6:0];
			end else if (r.waddr == SSS_WEN_OFF) begin
				if (r.wbe)
					n.wen = r.wdata;
			end else if (r.waddr == SSS_WSTS_OFF) begin
				if (r.wbe)
					sw_clr = r.wdata;
			end else if (r.waddr != SSS_STAT_OFF) begin
				n.bresp = SSS_RESP_SLVERR;
			end
		end
		// Pending wakes are sticky and a new enabled event beats any clear.
		n.wsts = (r.wsts & ~(sw_clr | {8{wake_clr}})) | (wake_evt & r.wen);
		if (r.rvalid && rready)
			n.rvalid = 1'b0;
		if (arvalid && r.arready) begin
			n.rvalid = 1'b1;
			n.rresp = SSS_RESP_OK;
			if (araddr == SSS_CTRL_OFF)
				n.rdata = {25'h0, r.ctrl};
			else if (araddr == SSS_WEN_OFF)
				n.rdata = {24'h0, r.wen};
			else if (araddr == SSS_STAT_OFF)
				n.rdata = {16'h0, status};
			else if (araddr == SSS_WSTS_OFF)
				n.rdata = {24'h0, r.wsts};
			else begin
				n.rdata = 32'h0;
				n.rresp = SSS_RESP_SLVERR;
			end
		end
		n.awready = !n.aw_held && !n.bvalid;
		n.wready = !n.w_held && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			r <= SSS_REG_RST;
		else
			r <= n;
	end

	assign awready = r.awready;
	assign wready = r.wready;
	assign bvalid = r.bvalid;
	assign bresp = r.bresp;
	assign arready = r.arready;
	assign rvalid = r.rvalid;
	assign rdata = r.rdata;
	assign rresp = r.rresp;
	assign ctrl = r.ctrl;
	assign wake_en = r.wen;
	assign wake_sts = r.wsts;

endmodule
`default_nettype wire

// [rtl/sss_sequencer.sv]
// System sleep state sequencer: power-state machine and rail outputs.
`default_nettype none
// Functional notes
// - Full-on: sleep idles, override offs, failure kills
// - Disk suspend: wake, override, deep, failure
// - Soft-off: wake, deep S5, failure
// - Deep sleep: wake, AC return, override, failure
// - Power return reboots or stays off in soft-off or disk suspend
// - Low battery holds off wake from S4/S5
// - Prior disk suspend returns to on or disk
// - Override soft-off continues into deep S5
// - Pending wakes survive power failure
// - Other forced-off events act as override
// - CPU rail off in sleep states
// - Own supply gated only by primary rail
// - Primary rail off only when safe
// - Disk and soft-off rails in S4/S5
// - Management rail off outside full-on when management off/gated
// - LAN rail off in sleep states with management off/gated and no wake-on-LAN
// - Core gate in C10 when rails tolerable
module sss_sequencer
	import sss_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic power_ok,
	input wire logic pwr_btn_override,
	input wire logic force_off_evt,
	input wire logic [7:0] wake_evt,
	input wire logic ac_power_present,
	input wire logic low_battery_n,
	input wire logic deep_entry_ok,
	input wire sss_mgmt_e mgmt_state,
	input wire logic cpu_c10_ready,
	output logic cpu_rail_off_n,
	output logic disk_suspend_rail_off_n,
	output logic soft_off_rail_off_n,
	output logic mgmt_rail_off_n,
	output logic lan_rail_off_n,
	output logic primary_rail_off_n,
	output logic core_deep_idle_gate_n
);

	sss_seq_s r;
	sss_seq_s n;
	sss_ctrl_s ctrl;
	logic [7:0] wake_en;
	logic [7:0] wake_sts;
	logic wake_clr;
	logic slp_clr;
	logic pfail;
	logic ovr;
	logic wake_hit;
	logic mg_down;
	logic [15:0] status;

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	sss_regs u_regs (
		.aclk(aclk),
		.aresetn(aresetn),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wake_evt(wake_evt),
		.wake_clr(wake_clr),
		.slp_clr(slp_clr),
		.status(status),
		.ctrl(ctrl),
		.wake_en(wake_en),
		.wake_sts(wake_sts)
	);

	assign status = {4'h0, r.rails, r.was_s4, r.from_s4, r.st};

	// ------------------------------------------------------------
	// Transition logic
	// ------------------------------------------------------------
	assign pfail = !power_ok;
	assign ovr = pwr_btn_override || force_off_evt;
	assign wake_hit = |(wake_sts & wake_en);
	assign mg_down = mgmt_state != MGMT_ON;

	always_comb begin
		n = r;
		slp_clr = 1'b0;
		unique case (r.st)
			ST_FULL_ON: begin
				if (pfail) begin
					n.st = ST_MECH_OFF;
				end else if (ovr) begin
					n.st = ctrl.ovr_to_disk ? ST_SUSP_DISK : ST_SOFT_OFF;
				end else if (ctrl.sleep_request_bit) begin
					n.st = ST_CPU_IDLE;
					slp_clr = 1'b1;
				end
			end
			ST_CPU_IDLE: begin
				if (pfail)
					n.st = ST_MECH_OFF;
				else if (ovr)
					n.st = ST_SOFT_OFF;
				else if (wake_hit)
					n.st = ST_FULL_ON;
			end
			ST_SUSP_DISK: begin
				if (pfail) begin
					n.st = ST_MECH_OFF;
				end else if (ovr) begin
					n.st = ST_SOFT_OFF;
				end else if (wake_hit) begin
					if (low_battery_n)
						n.st = ST_FULL_ON;
				end else if (deep_entry_ok && ctrl.deep_s4_en) begin
					n.st = ST_DEEP_SLEEP;
					n.from_s4 = 1'b1;
				end
			end
			ST_SOFT_OFF: begin
				// A soft-off reached by override drops into deep S5 next.
				if (pfail) begin
					n.st = ST_MECH_OFF;
				end else if (wake_hit) begin
					if (low_battery_n)
						n.st = ST_FULL_ON;
				end else if (deep_entry_ok && ctrl.deep_s5_en) begin
					n.st = ST_DEEP_SLEEP;
					n.from_s4 = 1'b0;
				end
			end
			ST_DEEP_SLEEP: begin
				if (pfail)
					n.st = ST_MECH_OFF;
				else if (wake_hit)
					n.st = ST_FULL_ON;
				else if (ovr)
					n.st = ST_SOFT_OFF;
				else if (ac_power_present)
					n.st = r.from_s4 ? ST_SUSP_DISK : ST_SOFT_OFF;
			end
			ST_MECH_OFF: begin
				if (power_ok) begin
					if (wake_hit)
						n.st = ST_FULL_ON;
					else if (r.was_s4)
						n.st = ctrl.stay_off ? ST_SUSP_DISK : ST_FULL_ON;
					else
						n.st = ctrl.stay_off ? ST_SOFT_OFF : ST_FULL_ON;
				end
			end
		endcase
		if (n.st == ST_MECH_OFF && r.st != ST_MECH_OFF)
			n.was_s4 = r.st == ST_SUSP_DISK ||
				(r.st == ST_DEEP_SLEEP && r.from_s4);
		wake_clr = n.st == ST_FULL_ON && r.st != ST_FULL_ON;
		// ------------------------------------------------------------
		// Rail outputs follow the next state so they match the state.
		// ------------------------------------------------------------
		n.rails = SSS_RAILS_ON;
		if (sss_sleeping(n.st)) begin
			n.rails.cpu_rail_off_n = 1'b0;
			n.rails.disk_suspend_rail_off_n = 1'b0;
			if (n.st != ST_SUSP_DISK && !(n.st == ST_DEEP_SLEEP && n.from_s4))
				n.rails.soft_off_rail_off_n = 1'b0;
			if (mg_down && !ctrl.host_wol && !ctrl.mgmt_wol)
				n.rails.lan_rail_off_n = 1'b0;
		end
		if (n.st != ST_FULL_ON && mg_down)
			n.rails.mgmt_rail_off_n = 1'b0;
		// The device's own supply hangs on the primary rail alone.
		if (n.st inside {ST_DEEP_SLEEP, ST_MECH_OFF})
			n.rails.primary_rail_off_n = 1'b0;
		if (n.st == ST_CPU_IDLE && cpu_c10_ready)
			n.rails.core_deep_idle_gate_n = 1'b0;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn)
			r <= SSS_SEQ_RST;
		else
			r <= n;
	end

	assign cpu_rail_off_n = r.rails.cpu_rail_off_n;
	assign disk_suspend_rail_off_n = r.rails.disk_suspend_rail_off_n;
	assign soft_off_rail_off_n = r.rails.soft_off_rail_off_n;
	assign mgmt_rail_off_n = r.rails.mgmt_rail_off_n;
	assign lan_rail_off_n = r.rails.lan_rail_off_n;
	assign primary_rail_off_n = r.rails.primary_rail_off_n;
	assign core_deep_idle_gate_n = r.rails.core_deep_idle_gate_n;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_ovr_to_soft;
		r.st == ST_FULL_ON && power_ok && ovr && !ctrl.ovr_to_disk;
	endsequence

	sequence s_deep_ready;
		power_ok && !wake_hit && deep_entry_ok && ctrl.deep_s5_en;
	endsequence

	property p_sleep_entry;
		r.st == ST_FULL_ON && power_ok && !ovr && ctrl.sleep_request_bit
			|=> r.st == ST_CPU_IDLE && !ctrl.sleep_request_bit;
	endproperty
	a_sleep_entry: assert property (p_sleep_entry)
		else $error("sleep request did not reach processor idle");

	property p_power_fail;
		!power_ok && r.st != ST_MECH_OFF
			|=> r.st == ST_MECH_OFF && !primary_rail_off_n;
	endproperty
	a_power_fail: assert property (p_power_fail)
		else $error("power failure did not reach mechanical off");

	property p_disk_wake;
		r.st == ST_SUSP_DISK && power_ok && !ovr && wake_hit &&
			low_battery_n |=> r.st == ST_FULL_ON && wake_sts == 8'h00;
	endproperty
	a_disk_wake: assert property (p_disk_wake)
		else $error("enabled wake did not leave disk suspend");

	property p_battery_hold;
		r.st inside {ST_SUSP_DISK, ST_SOFT_OFF} && !low_battery_n
			|=> r.st != ST_FULL_ON;
	endproperty
	a_battery_hold: assert property (p_battery_hold)
		else $error("wake taken while battery low");

	property p_ac_return;
		r.st == ST_DEEP_SLEEP && power_ok && !wake_hit && !ovr &&
			ac_power_present |=> r.st == (
			$past(r.from_s4) ? ST_SUSP_DISK : ST_SOFT_OFF);
	endproperty
	a_ac_return: assert property (p_ac_return)
		else $error("AC return went to the wrong sleep state");

	property p_disk_memory;
		r.st == ST_MECH_OFF && power_ok && r.was_s4
			|=> r.st inside {ST_FULL_ON, ST_SUSP_DISK};
	endproperty
	a_disk_memory: assert property (p_disk_memory)
		else $error("power return after disk suspend went to soft-off");

	property p_ovr_deep;
		s_ovr_to_soft ##1 s_deep_ready |=> r.st == ST_DEEP_SLEEP;
	endproperty
	a_ovr_deep: assert property (p_ovr_deep)
		else $error("override soft-off did not continue to deep S5");

	property p_cpu_rail;
		sss_sleeping(r.st) |-> !cpu_rail_off_n && !disk_suspend_rail_off_n;
	endproperty
	a_cpu_rail: assert property (p_cpu_rail)
		else $error("processor rail on in a sleep state");

	property p_primary_safe;
		!primary_rail_off_n |-> r.st inside {ST_DEEP_SLEEP, ST_MECH_OFF};
	endproperty
	a_primary_safe: assert property (p_primary_safe)
		else $error("primary rail off outside deep sleep or off");

	property p_full_on_rails;
		r.st == ST_FULL_ON |-> r.rails == SSS_RAILS_ON;
	endproperty
	a_full_on_rails: assert property (p_full_on_rails)
		else $error("rail output asserted in full-on");

	property p_core_gate;
		$fell(core_deep_idle_gate_n) |-> r.st == ST_CPU_IDLE &&
			$past(cpu_c10_ready);
	endproperty
	a_core_gate: assert property (p_core_gate)
		else $error("core gate asserted without C10 readiness");

endmodule
`default_nettype wire

// [verification/sss_rail_model.sv]
// Platform supply model that feeds power-good back to the sequencer.
`default_nettype none
module sss_rail_model (
	input wire logic mains_on,
	input wire logic primary_rail_off_n,
	output logic power_ok,
	output logic primary_up
);
	timeunit 1ns;
	timeprecision 1ns;
	// Power-good tracks the mains feed; the primary rail needs both.
	assign power_ok = mains_on;
	assign primary_up = mains_on & primary_rail_off_n;
endmodule
`default_nettype wire

// [verification/tb_system_sleep_state_sequencer.sv]
// Self-checking testbench of the system sleep state sequencer.
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module tb_system_sleep_state_sequencer import sss_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, mains, power_ok;
	logic pbo, foe, acp, lbn, deo, c10;
	logic [7:0] awaddr, araddr, wake_evt, cv;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [6:0] rails;
	logic pup;
	sss_mgmt_e ms;
	int n_errors, n_tests, k;

	sss_rail_model PWR (.mains_on(mains), .primary_rail_off_n(rails[5]),
		.power_ok(power_ok), .primary_up(pup));
	sss_sequencer DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
		.wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .power_ok(power_ok), .pwr_btn_override(pbo),
		.force_off_evt(foe), .wake_evt(wake_evt), .ac_power_present(acp),
		.low_battery_n(lbn), .deep_entry_ok(deo), .mgmt_state(ms),
		.cpu_c10_ready(c10), .cpu_rail_off_n(rails[0]),
		.disk_suspend_rail_off_n(rails[1]), .soft_off_rail_off_n(rails[2]),
		.mgmt_rail_off_n(rails[3]), .lan_rail_off_n(rails[4]),
		.primary_rail_off_n(rails[5]), .core_deep_idle_gate_n(rails[6]));

	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end

	task automatic report_and_stop;
		$display("errors %0d tests %0d", n_errors, n_tests);
		if (n_errors == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int t, i;
		bit ah, wh;
		ah = 0;
		wh = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (t = 0; t < 50 && !(ah && wh); t++) begin
			@(posedge aclk);
			if (!ah && awready === 1'b1) begin
				ah = 1;
				awvalid <= 1'b0;
			end
			if (!wh && wready === 1'b1) begin
				wh = 1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (bvalid === 1'b1) break;
		end
		rs = bresp;
		bready <= 1'b0;
		if (!(ah && wh) || i == 50) begin
			n_errors++;
			report_and_stop();
		end
	endtask

	task automatic rdr(input logic [7:0] a);
		int i, j;
		araddr <= a;
		arvalid <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) break;
		end
		arvalid <= 1'b0;
		rready <= 1'b1;
		for (j = 0; j < 50; j++) begin
			@(posedge aclk);
			if (rvalid === 1'b1) break;
		end
		rd = rdata;
		rs = rresp;
		rready <= 1'b0;
		if (i == 50 || j == 50) begin
			n_errors++;
			report_and_stop();
		end
	endtask

	task automatic setc(input logic [7:0] v);
		cv = v;
		wr(SSS_CTRL_OFF, {24'h0, v});
	endtask

	// Expected rails follow from the state, management state and WoL bits.
	task automatic chk_st(input sss_state_e s, input logic fd);
		logic [6:0] e;
		logic sl, mo;
		sl = s inside {ST_SUSP_DISK, ST_SOFT_OFF, ST_DEEP_SLEEP, ST_MECH_OFF};
		mo = ms != MGMT_ON;
		e[0] = !sl;
		e[1] = !sl;
		e[2] = !(s inside {ST_SOFT_OFF, ST_MECH_OFF} ||
			(s == ST_DEEP_SLEEP && !fd));
		e[3] = !(s != ST_FULL_ON && mo);
		e[4] = !(sl && mo && cv[6:5] == 2'b00);
		e[5] = !(s inside {ST_DEEP_SLEEP, ST_MECH_OFF});
		e[6] = !(s == ST_CPU_IDLE && c10);
		repeat (2) @(posedge aclk);
		rdr(SSS_STAT_OFF);
		`CHK("state", s, rd[2:0])
		`CHK("rails", e, rails)
		`CHK("status rails", e, rd[11:5])
		`CHK("primary up", e[5] & mains, pup)
	endtask

	task automatic wake(input logic [7:0] w);
		wake_evt <= w;
		@(posedge aclk);
		wake_evt <= 8'h00;
	endtask

	// A spare edge first lets an earlier wake settle and keeps pulses apart.
	task automatic ovr;
		@(posedge aclk);
		pbo <= 1'b1;
		@(posedge aclk);
		pbo <= 1'b0;
	endtask

	initial begin
		{awvalid, wvalid, bready, arvalid, rready, pbo, foe, acp} = '0;
		{deo, c10, aresetn} = '0;
		{awaddr, araddr, wake_evt, wdata, cv} = '0;
		wstrb = 4'hf;
		mains = 1'b1;
		lbn = 1'b1;
		ms = MGMT_ON;
		n_errors = 0;
		n_tests = 0;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk_st(ST_FULL_ON, 1'b0);
		for (k = 0; k < 4; k += 3) begin
			rdr(8'(k * 4));
			`CHK("reset value", 32'h0, rd)
		end
		rdr(8'h10);
		`CHK("unmapped rresp", SSS_RESP_SLVERR, rs)
		wr(8'h10, 32'hff);
		`CHK("unmapped bresp", SSS_RESP_SLVERR, rs)
		wr(SSS_WEN_OFF, 32'h01);
		wake(8'h01);
		wstrb <= 4'he;
		wr(SSS_WSTS_OFF, 32'h01);
		rdr(SSS_WSTS_OFF);
		`CHK("masked clear", 32'h1, rd)
		wstrb <= 4'hf;
		wr(SSS_WSTS_OFF, 32'h01);
		rdr(SSS_WSTS_OFF);
		`CHK("cleared wake", 32'h0, rd)
		wr(SSS_STAT_OFF, 32'hff);
		`CHK("status bresp", SSS_RESP_OK, rs)
		c10 <= 1'b1;
		setc(8'h01);
		chk_st(ST_CPU_IDLE, 1'b0);
		rdr(SSS_CTRL_OFF);
		`CHK("sleep bit", 32'h0, rd)
		wake(8'h01);
		chk_st(ST_FULL_ON, 1'b0);
		setc(8'h01);
		ovr();
		c10 <= 1'b0;
		chk_st(ST_SOFT_OFF, 1'b0);
		wake(8'h02);
		chk_st(ST_SOFT_OFF, 1'b0);
		lbn <= 1'b0;
		wake(8'h01);
		chk_st(ST_SOFT_OFF, 1'b0);
		lbn <= 1'b1;
		chk_st(ST_FULL_ON, 1'b0);
		rdr(SSS_WSTS_OFF);
		`CHK("pending", 32'h0, rd)
		setc(8'h04);
		ovr();
		chk_st(ST_SUSP_DISK, 1'b0);
		wake(8'h01);
		chk_st(ST_FULL_ON, 1'b0);
		ovr();
		ovr();
		chk_st(ST_SOFT_OFF, 1'b0);
		wake(8'h01);
		ovr();
		setc(8'h0c);
		deo <= 1'b1;
		chk_st(ST_DEEP_SLEEP, 1'b1);
		deo <= 1'b0;
		acp <= 1'b1;
		@(posedge aclk);
		acp <= 1'b0;
		chk_st(ST_SUSP_DISK, 1'b0);
		deo <= 1'b1;
		wake(8'h01);
		deo <= 1'b0;
		chk_st(ST_FULL_ON, 1'b0);
		setc(8'h10);
		deo <= 1'b1;
		foe <= 1'b1;
		@(posedge aclk);
		foe <= 1'b0;
		chk_st(ST_DEEP_SLEEP, 1'b0);
		deo <= 1'b0;
		ovr();
		chk_st(ST_SOFT_OFF, 1'b0);
		wake(8'h01);
		mains <= 1'b0;
		chk_st(ST_MECH_OFF, 1'b0);
		mains <= 1'b1;
		chk_st(ST_FULL_ON, 1'b0);
		setc(8'h02);
		mains <= 1'b0;
		chk_st(ST_MECH_OFF, 1'b0);
		mains <= 1'b1;
		chk_st(ST_SOFT_OFF, 1'b0);
		setc(8'h06);
		wake(8'h01);
		ovr();
		mains <= 1'b0;
		chk_st(ST_MECH_OFF, 1'b0);
		mains <= 1'b1;
		chk_st(ST_SUSP_DISK, 1'b0);
		lbn <= 1'b0;
		wake(8'h01);
		mains <= 1'b0;
		rdr(SSS_WSTS_OFF);
		`CHK("kept wake", 32'h1, rd)
		mains <= 1'b1;
		lbn <= 1'b1;
		chk_st(ST_FULL_ON, 1'b0);
		setc(8'h00);
		ms <= MGMT_OFF;
		chk_st(ST_FULL_ON, 1'b0);
		ovr();
		for (k = 0; k < 3; k++) begin
			ms <= k[0] ? MGMT_POWERGATED_STATE : MGMT_OFF;
			setc(8'(k * 32));
			chk_st(ST_SOFT_OFF, 1'b0);
		end
		report_and_stop();
	end
endmodule
`undef CHK
`default_nettype wire
